// ===== src/swp_sleep_wake_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from design files
`ifndef SWP_SLEEP_WAKE_MAP_SVH
`define SWP_SLEEP_WAKE_MAP_SVH

// Byte offsets on the register bus
`define SWP_OFS_REG_POWER    5'h00
`define SWP_OFS_CORE_STATUS  5'h04
`define SWP_OFS_INT_GLOBAL   5'h08
`define SWP_OFS_EVT_STATUS   5'h0c
`define SWP_OFS_EVT_ENABLE   5'h10
`define SWP_OFS_EVT_CLEAR    5'h14

// Regulator control fields
`define SWP_BIT_LOW_POWER_SEL 1
`define SWP_BIT_REG_KEEP_SET  0
`define SWP_RST_LOW_POWER_SEL 1'h0

// Core status fields, both read as one after reset
`define SWP_BIT_TIMEOUT       4
`define SWP_BIT_POWER_DOWN    3
`define SWP_RST_TIMEOUT       1'h1
`define SWP_RST_POWER_DOWN    1'h1

// Global interrupt control field
`define SWP_BIT_GLOBAL_EN     7
`define SWP_RST_GLOBAL_EN     1'h0

// Event bits
`define SWP_EVT_WIDTH         3
`define SWP_EVT_SLEPT         0
`define SWP_EVT_NOP           1
`define SWP_EVT_WOKE          2

// Timing
`define SWP_CLK_PERIOD_NS     50
`define SWP_SETTLE_NS         1000
`define SWP_SETTLE_CYCLES     ((`SWP_SETTLE_NS + `SWP_CLK_PERIOD_NS - 1) / `SWP_CLK_PERIOD_NS)
`define SWP_FORCED_NOP_CYCLES 2

`endif

// ===== src/swp_pkg.sv
// Types shared by the sleep and wake controller
// Assumes nothing of its surroundings
package swp_pkg;
	typedef enum logic [2:0] {
		SWP_AWAKE,
		SWP_ASLEEP,
		SWP_SETTLE,
		SWP_RESUME,
		SWP_NOPS,
		SWP_VECTOR
	} swp_state_t;

	typedef logic [7:0] swp_byte_t;
endpackage

// ===== src/swp_cycle_counter.sv
// Down counter that pulses done after a loaded number of cycles
// Assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module swp_cycle_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] cycles,
	output logic                  busy,
	output logic                  done
);
	logic [WIDTH-1:0] count;

	// Count down and flag the last cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else if (start) begin
			count <= cycles;
			busy  <= 1'b1;
			done  <= 1'b0;
		end else if (busy) begin
			if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
				done  <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule // swp_cycle_counter
`default_nettype wire

// ===== src/swp_sleep_wake.sv
// Sleep and wake control with regulator power mode and status bits
// Assumes core pulses sleepExec and interrupt sources on the same clock
//
// How it works
// - Enabled, flagged source counts even without global enable
// - Already pending candidate turns sleep into no-op
// - No-op path leaves watchdog and status untouched
// - Late candidate completes sleep, then wakes immediately
// - Completed sleep clears watchdog, sets timeout, clears power-down
// - Low-power select one puts regulator low in sleep
// - Select zero keeps regulator normal, fast exit
// - Low-power wake inserts extra settling delay
// - Unregulated variant always lowest power, no delay
// - Regulator bit zero reads one; software keeps it
// - Regulator bits seven to two read zero
// - Wake needs source enable, global enable irrelevant
// - After wake run next instruction, then maybe vector
`timescale 1ns/1ps
`default_nettype none
`include "swp_sleep_wake_map.svh"
module swp_sleep_wake #(
	parameter int SOURCES     = 8,
	parameter bit UNREGULATED = 1'b0,
	parameter int CNT_WIDTH   = 8
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [4:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	input  wire logic               sleepExec,
	input  wire logic [SOURCES-1:0] irqEnable,
	input  wire logic [SOURCES-1:0] irqFlag,
	output logic                    cpuClockRun,
	output logic                    regLowPower,
	output logic                    wdtClear,
	output logic                    sleepNop,
	output logic                    resumeExec,
	output logic                    forcedNop,
	output logic                    vectorFetch,
	output logic                    globalIntEnable,
	output logic                    irq
);
	import swp_pkg::*;

	swp_state_t                state;
	logic                      candidate;
	logic                      candidatePrev;
	logic                      lowPowerSel;
	logic                      sleepLowPower;
	logic                      timeoutStatus;
	logic                      powerDownStatus;
	logic [`SWP_EVT_WIDTH-1:0] evtStatus;
	logic [`SWP_EVT_WIDTH-1:0] evtEnable;
	logic [`SWP_EVT_WIDTH-1:0] evtSet;
	logic                      accept;
	logic                      wrStrobe;
	logic                      enterSleep;
	logic                      nopSleep;
	logic                      wakeNow;
	logic                      settleStart;
	logic                      settleDone;
	logic                      nopStart;
	logic                      nopBusy;
	logic                      nopDone;
	logic [31:0]               next_readdata;
	swp_byte_t                 regPowerValue;
	swp_byte_t                 coreStatusValue;
	swp_byte_t                 intGlobalValue;

	// candidate from enable and flag only
	assign candidate = |(irqEnable & irqFlag);

	// pending before sleep means seen a cycle earlier
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			candidatePrev <= 1'b0;
		end else begin
			candidatePrev <= candidate;
		end
	end

	// pending candidate selects the no-op path
	assign nopSleep   = (state == SWP_AWAKE) && sleepExec && candidatePrev;
	assign enterSleep = (state == SWP_AWAKE) && sleepExec && !candidatePrev;
	// wake on candidate whatever the global enable
	assign wakeNow    = (state == SWP_ASLEEP) && candidate;
	// extra delay only for regulated low-power sleep
	assign settleStart = wakeNow && sleepLowPower && !UNREGULATED;
	assign nopStart    = (state == SWP_RESUME) && globalIntEnable;

	// Bus handshake: one wait cycle, then answer
	assign accept   = (avs_read || avs_write) && !avs_waitrequest;
	assign wrStrobe = accept && avs_write && avs_byteenable[0];

	assign regPowerValue = {6'h00, lowPowerSel, 1'b1};
	assign coreStatusValue = {3'h0, timeoutStatus, powerDownStatus, 3'h0};
	assign intGlobalValue = {globalIntEnable, 7'h00};

	// Settling delay counter
	swp_cycle_counter #(
		.WIDTH(CNT_WIDTH)
	) settleCounter (
		.clk   (clk),
		.rst_n (rst_n),
		.start (settleStart),
		.cycles(CNT_WIDTH'(`SWP_SETTLE_CYCLES)),
		.busy  (),
		.done  (settleDone)
	);

	// Forced no-op counter
	swp_cycle_counter #(
		.WIDTH(CNT_WIDTH)
	) nopCounter (
		.clk   (clk),
		.rst_n (rst_n),
		.start (nopStart),
		.cycles(CNT_WIDTH'(`SWP_FORCED_NOP_CYCLES)),
		.busy  (nopBusy),
		.done  (nopDone)
	);

	// Sleep sequence
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SWP_AWAKE;
		end else begin
			unique case (state)
				SWP_AWAKE: begin
					// late candidate still completes sleep entry
					if (enterSleep) begin
						state <= SWP_ASLEEP;
					end
				end
				SWP_ASLEEP: begin
					// leave sleep as soon as candidate seen
					if (settleStart) begin
						state <= SWP_SETTLE;
					end else if (wakeNow) begin
						state <= SWP_RESUME;
					end
				end
				SWP_SETTLE: begin
					if (settleDone) begin
						state <= SWP_RESUME;
					end
				end
				SWP_RESUME: begin
					if (globalIntEnable) begin
						state <= SWP_NOPS;
					end else begin
						state <= SWP_AWAKE;
					end
				end
				SWP_NOPS: begin
					if (nopDone) begin
						state <= SWP_VECTOR;
					end
				end
				SWP_VECTOR: begin
					state <= SWP_AWAKE;
				end
				default: begin
					state <= SWP_AWAKE;
				end
			endcase
		end
	end

	// core clock stops, restarts on wake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuClockRun <= 1'b1;
		end else begin
			cpuClockRun <= !(enterSleep || (state == SWP_ASLEEP && !wakeNow)
				|| settleStart || (state == SWP_SETTLE && !settleDone));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resumeExec <= 1'b0;
		end else begin
			resumeExec <= (state == SWP_SETTLE && settleDone)
				|| (wakeNow && !settleStart);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			forcedNop   <= 1'b0;
			vectorFetch <= 1'b0;
		end else begin
			forcedNop   <= nopStart || (nopBusy && state == SWP_NOPS);
			vectorFetch <= (state == SWP_NOPS) && nopDone;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleepNop <= 1'b0;
		end else begin
			sleepNop <= nopSleep;
		end
	end

	// watchdog cleared on sleep entry and on wake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdtClear <= 1'b0;
		end else begin
			wdtClear <= enterSleep || wakeNow;
		end
	end

	// Regulator mode for the current sleep
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleepLowPower <= 1'b0;
			regLowPower   <= 1'b0;
		end else begin
			if (enterSleep) begin
				sleepLowPower <= lowPowerSel;
			end
			// normal regulator when select is zero in the regulated variant
			regLowPower <= (enterSleep && (lowPowerSel || UNREGULATED))
				|| (state == SWP_ASLEEP && !wakeNow && (sleepLowPower || UNREGULATED));
		end
	end

	// timeout set and power-down cleared on completed sleep
	// no-op path leaves both bits alone
	// power-down bit keeps its value after a no-op sleep, set or cleared
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timeoutStatus   <= `SWP_RST_TIMEOUT;
			powerDownStatus <= `SWP_RST_POWER_DOWN;
		end else if (enterSleep) begin
			timeoutStatus   <= 1'b1;
			powerDownStatus <= 1'b0;
		end
	end

	// Regulator select register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lowPowerSel <= `SWP_RST_LOW_POWER_SEL;
		end else if (wrStrobe && avs_address == `SWP_OFS_REG_POWER) begin
			// written bit zero ignored, always reads one
			lowPowerSel <= avs_writedata[`SWP_BIT_LOW_POWER_SEL];
		end
	end

	// Global interrupt enable register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			globalIntEnable <= `SWP_RST_GLOBAL_EN;
		end else if (wrStrobe && avs_address == `SWP_OFS_INT_GLOBAL) begin
			globalIntEnable <= avs_writedata[`SWP_BIT_GLOBAL_EN];
		end
	end

	// Event enable register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evtEnable <= '0;
		end else if (wrStrobe && avs_address == `SWP_OFS_EVT_ENABLE) begin
			evtEnable <= avs_writedata[`SWP_EVT_WIDTH-1:0];
		end
	end

	// Sticky events, set wins over clear
	always_comb begin
		evtSet = '0;
		evtSet[`SWP_EVT_SLEPT] = enterSleep;
		evtSet[`SWP_EVT_NOP]   = nopSleep;
		evtSet[`SWP_EVT_WOKE]  = wakeNow;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evtStatus <= '0;
		end else if (wrStrobe && avs_address == `SWP_OFS_EVT_CLEAR) begin
			evtStatus <= (evtStatus & ~avs_writedata[`SWP_EVT_WIDTH-1:0]) | evtSet;
		end else begin
			evtStatus <= evtStatus | evtSet;
		end
	end

	// Level interrupt output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |((evtStatus | evtSet) & evtEnable);
		end
	end

	// Read data mux, unmapped reads zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avs_address)
			`SWP_OFS_REG_POWER:   next_readdata = {24'h00_0000, regPowerValue};
			`SWP_OFS_CORE_STATUS: next_readdata = {24'h00_0000, coreStatusValue};
			`SWP_OFS_INT_GLOBAL:  next_readdata = {24'h00_0000, intGlobalValue};
			`SWP_OFS_EVT_STATUS:  next_readdata = {29'h0000_0000, evtStatus};
			`SWP_OFS_EVT_ENABLE:  next_readdata = {29'h0000_0000, evtEnable};
			default:              next_readdata = 32'h0000_0000;
		endcase
	end

	// Bus slave: waitrequest drops for one cycle per request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
		end
	end

	// low-power select is software's choice, no check here
endmodule // swp_sleep_wake
`default_nettype wire

// ===== dv/swp_sleep_wake_monitor.sv
// Concurrent checks on the sleep and wake controller ports
// Assumes binding into every swp_sleep_wake instance
`timescale 1ns/1ps
`default_nettype none
`include "swp_sleep_wake_map.svh"
module swp_sleep_wake_monitor #(
	parameter int SOURCES     = 8,
	parameter bit UNREGULATED = 1'b0
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic [4:0]         avs_address,
	input wire logic               avs_read,
	input wire logic [31:0]        avs_readdata,
	input wire logic               avs_waitrequest,
	input wire logic               sleepExec,
	input wire logic [SOURCES-1:0] irqEnable,
	input wire logic [SOURCES-1:0] irqFlag,
	input wire logic               cpuClockRun,
	input wire logic               regLowPower,
	input wire logic               wdtClear,
	input wire logic               sleepNop,
	input wire logic               resumeExec,
	input wire logic               forcedNop,
	input wire logic               vectorFetch,
	input wire logic               globalIntEnable
);
	wire logic cand = |(irqEnable & irqFlag);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_nop_pending: assert property (sleepNop |-> $past(sleepExec) && $past(cand, 2))
		else $error("no-op sleep without pending source");
	a_nop_quiet: assert property (sleepNop |-> !wdtClear && cpuClockRun)
		else $error("no-op sleep touched watchdog or clock");
	a_entry_clear: assert property ($fell(cpuClockRun) |-> wdtClear && $past(sleepExec))
		else $error("sleep entry without watchdog clear");
	a_fast_wake: assert property ($fell(cpuClockRun) && !regLowPower && cand |=> resumeExec)
		else $error("late source did not wake at once");
	a_lp_settle: assert property (!UNREGULATED && !cpuClockRun && regLowPower && cand |=>
		wdtClear && !regLowPower ##1 !cpuClockRun [*8])
		else $error("low-power wake without settling delay");
	a_reg_low: assert property (regLowPower |-> !cpuClockRun)
		else $error("regulator low while core runs");
	a_unreg_fast: assert property (UNREGULATED && !cpuClockRun && cand |=> resumeExec && cpuClockRun)
		else $error("unregulated wake was delayed");
	a_wake_run: assert property ($rose(cpuClockRun) |-> resumeExec)
		else $error("clock restart without resume");
	a_vector_nops: assert property (vectorFetch |->
		globalIntEnable && $past(forcedNop) && $past(forcedNop, 3))
		else $error("vector fetch without forced no-ops");
	a_reg_bits: assert property (!avs_waitrequest && $past(avs_read) &&
		$past(avs_address) == `SWP_OFS_REG_POWER |-> avs_readdata[7:2] == 6'h00 && avs_readdata[0])
		else $error("regulator register fixed bits wrong");
endmodule // swp_sleep_wake_monitor
bind swp_sleep_wake swp_sleep_wake_monitor #(.SOURCES(SOURCES), .UNREGULATED(UNREGULATED))
	u_swp_sleep_wake_monitor (
	.clk, .rst_n, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest, .sleepExec,
	.irqEnable, .irqFlag, .cpuClockRun, .regLowPower, .wdtClear, .sleepNop, .resumeExec,
	.forcedNop, .vectorFetch, .globalIntEnable);
`default_nettype wire

// ===== dv/swp_sleep_wake_tb.sv
// Self-checking bench for the sleep and wake controller
// Assumes the monitor file is compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "swp_sleep_wake_map.svh"
module swp_sleep_wake_tb;
	import swp_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic        sleepExec = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0]  avs_byteenable = 4'h1;
	logic [7:0]  irqEnable = 8'h00, irqFlag = 8'h00, en;
	logic        avs_waitrequest, cpuClockRun, regLowPower, wdtClear, sleepNop, resumeExec;
	logic        forcedNop, vectorFetch, globalIntEnable, irq;
	logic        regLowPowerU, resumeExecU;
	int          failures = 0, checks = 0, cyc = 0, n, nU, nf, expEvt = 0;
	swp_sleep_wake u_swp_sleep_wake (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sleepExec,
		.irqEnable, .irqFlag, .cpuClockRun, .regLowPower, .wdtClear, .sleepNop, .resumeExec,
		.forcedNop, .vectorFetch, .globalIntEnable, .irq);
	swp_sleep_wake #(.UNREGULATED(1'b1)) u_swp_sleep_wake_unreg (.clk, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata(),
		.avs_waitrequest(), .sleepExec, .irqEnable, .irqFlag, .cpuClockRun(),
		.regLowPower(regLowPowerU), .wdtClear(), .sleepNop(), .resumeExec(resumeExecU),
		.forcedNop(), .vectorFetch(), .globalIntEnable(), .irq());
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			failures = failures + 1;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, q, exp);
	endtask
	task automatic doSleep(input logic late);
		@(posedge clk);
		sleepExec <= 1'b1;
		if (late) irqFlag <= irqFlag | en;
		@(posedge clk);
		sleepExec <= 1'b0;
		@(negedge clk);
	endtask
	task automatic waitWake(input logic raise);
		n = 0;
		nU = 0;
		if (raise) begin
			@(posedge clk);
			irqFlag <= irqFlag | en;
		end
		while (resumeExec !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
			if (resumeExecU === 1'b1) nU = n;
		end
		@(posedge clk);
		irqFlag <= 8'h00;
	endtask
	task automatic enterSleep(input logic late);
		@(posedge clk);
		en = 8'($urandom) | 8'h01;
		irqEnable <= en;
		irqFlag <= ~en;
		doSleep(late);
		chk("wdtClear", wdtClear, 1'b1);
		chk("cpuClockRun", cpuClockRun, 1'b0);
		expEvt = expEvt | 3'h1;
	endtask
	initial begin
		void'($urandom(48));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(`SWP_OFS_REG_POWER, 32'h01, "regpower");
		rd(`SWP_OFS_CORE_STATUS, 32'h18, "status");
		rd(`SWP_OFS_INT_GLOBAL, 32'h00, "intglobal");
		rd(5'h1c, 32'h00, "unmapped");
		bus(1'b1, `SWP_OFS_CORE_STATUS, 8'h00);
		rd(`SWP_OFS_CORE_STATUS, 32'h18, "status ro");
		bus(1'b1, `SWP_OFS_REG_POWER, 8'hfd);
		rd(`SWP_OFS_REG_POWER, 32'h01, "regpower wr");
		$display("test registers done");
		en = 8'h01 << $urandom_range(7, 0);
		irqEnable <= en;
		irqFlag <= en | (8'($urandom) & ~en);
		doSleep(1'b0);
		chk("sleepNop", sleepNop, 1'b1);
		chk("nop wdtClear", wdtClear, 1'b0);
		chk("nop clock", cpuClockRun, 1'b1);
		rd(`SWP_OFS_CORE_STATUS, 32'h18, "nop status");
		expEvt = expEvt | 3'h2;
		irqFlag <= 8'h00;
		$display("test no-op sleep done");
		enterSleep(1'b0);
		chk("normal reg", regLowPower, 1'b0);
		chk("unreg low", regLowPowerU, 1'b1);
		rd(`SWP_OFS_CORE_STATUS, 32'h10, "slept status");
		waitWake(1'b1);
		chk("fast wake", n, 2);
		repeat (6) @(negedge clk) chk("no vector", vectorFetch, 1'b0);
		expEvt = expEvt | 3'h4;
		$display("test normal sleep done");
		enterSleep(1'b1);
		waitWake(1'b0);
		chk("late wake", n, 1);
		$display("test late source done");
		bus(1'b1, `SWP_OFS_REG_POWER, 8'h03);
		bus(1'b1, `SWP_OFS_INT_GLOBAL, 8'h80);
		enterSleep(1'b0);
		chk("gie", globalIntEnable, 1'b1);
		chk("low reg", regLowPower, 1'b1);
		waitWake(1'b1);
		chk("settle", n, `SWP_SETTLE_CYCLES + 3);
		chk("unreg no delay", nU, 2);
		n = 0;
		nf = 0;
		while (vectorFetch !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
			if (forcedNop === 1'b1) nf++;
		end
		chk("vector delay", n, `SWP_FORCED_NOP_CYCLES + 2);
		chk("forced nops", nf, `SWP_FORCED_NOP_CYCLES + 1);
		bus(1'b1, `SWP_OFS_INT_GLOBAL, 8'h00);
		$display("test low-power sleep done");
		chk("irq masked", irq, 1'b0);
		bus(1'b1, `SWP_OFS_EVT_ENABLE, 8'h07);
		rd(`SWP_OFS_EVT_STATUS, expEvt, "events");
		chk("irq raised", irq, 1'b1);
		bus(1'b1, `SWP_OFS_EVT_CLEAR, 8'h07);
		rd(`SWP_OFS_EVT_CLEAR, 32'h00, "clear reg");
		rd(`SWP_OFS_EVT_STATUS, 32'h00, "events clr");
		chk("irq cleared", irq, 1'b0);
		$display("test interrupt done");
		finish_test();
	end
endmodule // swp_sleep_wake_tb
`default_nettype wire
